// ==== design/storage_seq_map.svh ====
// constants of the storage charge state sequencer
`ifndef STORAGE_SEQ_MAP_SVH
`define STORAGE_SEQ_MAP_SVH

// ==========================================================
// timing
`define CLK_KHZ 10000
`define STARTUP_MS 20
`define LOWBAT_US 16
`define WARN_PULSE_US 100
`define BOOST_KHZ 1000

// ==========================================================
// levels on the 5-bit storage node scale
`define CEIL_LO 5'h18
`define CEIL_HI 5'h1e
`define LVL_DEPLETED 5'h01

// ==========================================================
// field codes and reset values
`define ICH_EMERG 3'h4
`define ICH_RST 3'h0
`define VMIN_RST 3'h0
`define VFIX_RST 4'h0
`define VEW_RST 4'h0
`define VSET_RST 4'h0
`define PROF_RST 6'h01
`define PROF_FIXED 6'h00

`endif

// ==== design/storage_seq_pkg.sv ====
// types of the storage charge state sequencer
package storage_seq_pkg;

  // ========================================================
  // operating states
  typedef enum logic [1:0] {
    ST_STARTUP = 2'b00,
    ST_STANDBY = 2'b01,
    ST_CHARGE = 2'b10,
    ST_ACTIVE = 2'b11
  } op_state_t;

endpackage

// ==== design/hold_timer.sv ====
// persistence timer: done after a condition holds for N cycles
`timescale 1ns/100ps
module hold_timer #(
  parameter int W = 18,
  parameter logic [W-1:0] N = {{(W-1){1'b0}}, 1'b1}
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_run,
  output logic o_done
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  // count while running, saturate at the target, clear on drop
  always_comb begin
    cnt_nxt = '0;
    if (i_run) begin
      cnt_nxt = (cnt_r == N) ? cnt_r : cnt_r + 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign o_done = i_run && (cnt_r == N);

endmodule // hold_timer

// ==== design/boost_phase_gen.sv ====
// two-phase switch timing for the boost converter
`timescale 1ns/100ps
module boost_phase_gen #(
  parameter int HALF = 5
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_en,
  output logic o_primary,
  output logic o_secondary
);

  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic sec_r;
  logic sec_nxt;
  logic pri_out_r;
  logic sec_out_r;

  // alternate phases every half period, idle when disabled
  always_comb begin
    cnt_nxt = 8'h00;
    sec_nxt = 1'b0;
    if (i_en) begin
      sec_nxt = sec_r;
      cnt_nxt = cnt_r + 8'h01;
      if (cnt_r == 8'(HALF - 1)) begin
        cnt_nxt = 8'h00;
        sec_nxt = !sec_r;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cnt_r <= 8'h00;
      sec_r <= 1'b0;
      pri_out_r <= 1'b0;
      sec_out_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      sec_r <= sec_nxt;
      pri_out_r <= i_en && !sec_nxt;
      sec_out_r <= i_en && sec_nxt;
    end
  end

  assign o_primary = pri_out_r;
  assign o_secondary = sec_out_r;

endmodule // boost_phase_gen

// ==== design/storage_charge_state_sequencer.sv ====
// operating-state sequencer of a battery energy manager
// ==========================================================
// Summary of operation
// R1 - above power-on level connect outputs; enter standby 20 ms later
// R2 - host waits about 20 ms before bus access; early writes ignored
// R3 - ready pin and ready bit low in standby
// R4 - on-demand, continuous, or start pin in auto mode leave standby
// R5 - settings kept while supply stays up; only reset clears them
// R6 - four normal current codes; code 4h emergency; floor still watched
// R7 - charging pauses below battery floor and resumes above it
// R8 - weak battery flag after floor dip longer than 16 us in charge
// R9 - target is fixed setting for profile 0, else learned target
// R10 - charge target never above the selected storage ceiling
// R11 - storage level reported as five-bit status; last value held while in standby
// R12 - on-demand enters active when end-of-charge level reached
// R13 - continuous stays in charge and tops up to the target
// R14 - on-demand active request enters active early
// R15 - on-demand active ends to standby when enable cleared
// R16 - continuous: request toggles active/charge; both cleared to standby
// R17 - enabled warning below threshold in active sets flag, pulses ready
// R18 - early-warning enable defaults to disabled
// R19 - output low in active sets alarm and ready low until next charge
// R20 - precharge below 1.6 V, constant-current boost above
// R21 - boost primary: storage and third switch; secondary: second, fourth
// R22 - active regulates outputs to the selected output level
// R23 - ready status bit mirrors ready pin
// R24 - continuous ready goes high when storage reaches fixed target
`timescale 1ns/100ps
`include "storage_seq_map.svh"
module storage_charge_state_sequencer
  import storage_seq_pkg::*;
#(
  parameter int STARTUP_CYC = `STARTUP_MS * `CLK_KHZ,
  parameter int WARN_PULSE_CYC = `WARN_PULSE_US * `CLK_KHZ / 1000
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_por_ok,
  input wire logic i_start,
  input wire logic i_bat_low,
  input wire logic i_above_pre,
  input wire logic i_out_low,
  input wire logic [4:0] i_cap_level,
  input wire logic [3:0] i_vopt,
  input wire logic i_cfg_wr,
  input wire logic i_eod,
  input wire logic i_ecm,
  input wire logic i_act,
  input wire logic i_automode,
  input wire logic [2:0] i_ich,
  input wire logic [2:0] i_vmin,
  input wire logic [3:0] i_vfix,
  input wire logic i_vcapmax,
  input wire logic [5:0] i_prof,
  input wire logic i_eew,
  input wire logic [3:0] i_vew,
  input wire logic [3:0] i_vset,
  input wire logic i_status_clr,
  output logic [1:0] o_state,
  output logic o_out_connect,
  output logic o_ready,
  output logic o_ready_bit,
  output logic o_warning_flag,
  output logic o_output_alarm,
  output logic o_weak_battery,
  output logic [4:0] o_cap_level,
  output logic [4:0] o_charge_target,
  output logic o_precharge_on,
  output logic o_boost_on,
  output logic o_emergency,
  output logic [2:0] o_ich,
  output logic [2:0] o_vmin,
  output logic o_sw_cap,
  output logic o_sw2,
  output logic o_sw3,
  output logic o_sw4,
  output logic o_regulate,
  output logic [3:0] o_vset
);

  localparam int LOWBAT_CYC = `LOWBAT_US * `CLK_KHZ / 1000;
  localparam int BOOST_HALF = `CLK_KHZ / `BOOST_KHZ / 2;

  // maps a 4-bit voltage code onto the storage level scale
  function automatic logic [4:0] to_level(input logic [3:0] code);
    return {code, 1'b0};
  endfunction

  // ========================================================
  // pin synchronisers
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  logic por_s, start_s, bat_low_s, above_pre_s, out_low_s;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      sync1_r <= 5'h00;
      sync2_r <= 5'h00;
    end else begin
      sync1_r <= {i_por_ok, i_start, i_bat_low, i_above_pre, i_out_low};
      sync2_r <= sync1_r;
    end
  end
  assign {por_s, start_s, bat_low_s, above_pre_s, out_low_s} = sync2_r;

  // ========================================================
  // settings
  logic eod_r, ecm_r, act_r, auto_r, vcapmax_r, eew_r;
  logic eod_nxt, ecm_nxt, act_nxt, auto_nxt, vcapmax_nxt, eew_nxt;
  logic [2:0] ich_r, ich_nxt, vmin_r, vmin_nxt;
  logic [3:0] vfix_r, vfix_nxt, vew_r, vew_nxt, vset_r, vset_nxt;
  logic [5:0] prof_r, prof_nxt;
  op_state_t state_r, state_nxt;

  // load on write; writes during startup are dropped
  always_comb begin
    {eod_nxt, ecm_nxt, act_nxt, auto_nxt} = {eod_r, ecm_r, act_r, auto_r};
    {ich_nxt, vmin_nxt, vfix_nxt} = {ich_r, vmin_r, vfix_r};
    {vcapmax_nxt, prof_nxt, eew_nxt} = {vcapmax_r, prof_r, eew_r};
    {vew_nxt, vset_nxt} = {vew_r, vset_r};
    if (i_cfg_wr && state_r != ST_STARTUP) begin // R2
      {eod_nxt, ecm_nxt, act_nxt, auto_nxt} = {i_eod, i_ecm, i_act,
                                               i_automode};
      {ich_nxt, vmin_nxt, vfix_nxt} = {i_ich, i_vmin, i_vfix};
      {vcapmax_nxt, prof_nxt, eew_nxt} = {i_vcapmax, i_prof, i_eew};
      {vew_nxt, vset_nxt} = {i_vew, i_vset};
    end
  end

  // only reset (loss of supply) returns defaults
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin // R5
      {eod_r, ecm_r, act_r, auto_r} <= 4'h0;
      ich_r <= `ICH_RST;
      vmin_r <= `VMIN_RST;
      vfix_r <= `VFIX_RST;
      vcapmax_r <= 1'b0;
      prof_r <= `PROF_RST;
      eew_r <= 1'b0; // R18
      vew_r <= `VEW_RST;
      vset_r <= `VSET_RST;
    end else begin
      {eod_r, ecm_r, act_r, auto_r} <= {eod_nxt, ecm_nxt, act_nxt, auto_nxt};
      {ich_r, vmin_r, vfix_r} <= {ich_nxt, vmin_nxt, vfix_nxt};
      {vcapmax_r, prof_r, eew_r} <= {vcapmax_nxt, prof_nxt, eew_nxt};
      {vew_r, vset_r} <= {vew_nxt, vset_nxt};
    end
  end

  // ========================================================
  // targets and level compares
  logic [4:0] ceil_lvl, want_lvl, end_lvl, fix_lvl;
  logic demand, reached, fix_reached, depleted, below_warn;

  always_comb begin
    ceil_lvl = vcapmax_r ? `CEIL_HI : `CEIL_LO;
    want_lvl = (prof_r == `PROF_FIXED) ? to_level(vfix_r)
                                       : to_level(i_vopt); // R9
    end_lvl = (want_lvl > ceil_lvl) ? ceil_lvl : want_lvl; // R10
    fix_lvl = (to_level(vfix_r) > ceil_lvl) ? ceil_lvl : to_level(vfix_r);
    reached = i_cap_level >= end_lvl;
    fix_reached = i_cap_level >= fix_lvl;
    depleted = i_cap_level < `LVL_DEPLETED;
    below_warn = i_cap_level < to_level(vew_r);
    demand = eod_r || (auto_r && start_s); // R4
  end

  // ========================================================
  // timers
  logic startup_done, lowbat_done, pulse_done;
  logic pulse_r, pulse_nxt;

  hold_timer #(.W(18), .N(18'(STARTUP_CYC))) u_startup (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_run(state_r == ST_STARTUP && por_s),
    .o_done(startup_done)
  );

  // one cycle beyond the limit: strictly longer than the dip time
  hold_timer #(.W(18), .N(18'(LOWBAT_CYC + 1))) u_lowbat (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_run(state_r == ST_CHARGE && bat_low_s), // R8
    .o_done(lowbat_done)
  );

  hold_timer #(.W(18), .N(18'(WARN_PULSE_CYC))) u_pulse (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_run(pulse_r),
    .o_done(pulse_done)
  );

  // ========================================================
  // state machine
  logic cont_r, cont_nxt;

  always_comb begin
    state_nxt = state_r;
    cont_nxt = cont_r;
    unique case (state_r)
      ST_STARTUP: begin
        if (startup_done) begin // R1
          state_nxt = ST_STANDBY;
        end
      end
      ST_STANDBY: begin
        cont_nxt = ecm_r;
        if (ecm_r || demand) begin // R4
          state_nxt = ST_CHARGE;
        end
      end
      ST_CHARGE: begin
        if (cont_r) begin
          if (!ecm_r && !act_r) begin // R16
            state_nxt = ST_STANDBY;
          end else if (act_r) begin // R16
            state_nxt = ST_ACTIVE;
          end
        end else if (!demand) begin
          state_nxt = ST_STANDBY;
        end else if (act_r || reached) begin // R12 R14
          state_nxt = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (cont_r) begin
          if (!ecm_r && !act_r) begin // R16
            state_nxt = ST_STANDBY;
          end else if (!act_r) begin // R16
            state_nxt = ST_CHARGE;
          end
        end else if (!demand) begin // R15
          state_nxt = ST_STANDBY;
        end
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_r <= ST_STARTUP;
      cont_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cont_r <= cont_nxt;
    end
  end

  // ========================================================
  // charge path, flags, ready
  logic run, pre_nxt, boost_nxt, boost_r, pre_r, reg_r, conn_r;
  logic weak_r, weak_nxt, alarm_r, alarm_nxt, warn_r, warn_nxt;
  logic base_r, base_nxt, rdy_r, rdy_nxt, fixq_r, actq_r;
  logic [4:0] lvl_r, lvl_nxt, tgt_r;
  logic chg_entry;

  always_comb begin
    // pause below floor; continuous tops up whenever below target
    run = state_r == ST_CHARGE && !bat_low_s && !reached; // R7 R13 R6
    pre_nxt = run && !above_pre_s; // R20
    boost_nxt = run && above_pre_s; // R20
    chg_entry = state_nxt == ST_CHARGE && state_r != ST_CHARGE;
    lvl_nxt = (state_r == ST_STANDBY) ? lvl_r : i_cap_level; // R11
    // hardware set wins over a clear in the same cycle
    weak_nxt = lowbat_done || (weak_r && !i_status_clr); // R8
    alarm_nxt = (state_r == ST_ACTIVE && out_low_s) ||
                (alarm_r && !chg_entry); // R19
    warn_nxt = (eew_r && state_r == ST_ACTIVE && below_warn) ||
               (warn_r && !i_status_clr); // R17
    pulse_nxt = (warn_nxt && !warn_r) || (pulse_r && !pulse_done); // R17
    base_nxt = 1'b0;
    if (state_nxt == ST_CHARGE || state_nxt == ST_ACTIVE) begin
      if (!cont_nxt) begin
        base_nxt = state_nxt == ST_ACTIVE && !depleted;
      end else begin
        base_nxt = (base_r || (fix_reached && !fixq_r)) && // R24
                   !depleted && !(actq_r && !act_r);
      end
    end
    rdy_nxt = base_nxt && !alarm_nxt && !pulse_nxt; // R3 R19
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      {pre_r, boost_r, reg_r, conn_r} <= 4'h0;
      {weak_r, alarm_r, warn_r, pulse_r} <= 4'h0;
      {base_r, rdy_r, fixq_r, actq_r} <= 4'h0;
      lvl_r <= 5'h00;
      tgt_r <= 5'h00;
    end else begin
      pre_r <= pre_nxt;
      boost_r <= boost_nxt;
      reg_r <= state_nxt == ST_ACTIVE; // R22
      conn_r <= por_s; // R1
      {weak_r, alarm_r, warn_r, pulse_r} <= {weak_nxt, alarm_nxt, warn_nxt,
                                           pulse_nxt};
      {base_r, rdy_r} <= {base_nxt, rdy_nxt};
      fixq_r <= fix_reached;
      actq_r <= act_r;
      lvl_r <= lvl_nxt;
      tgt_r <= end_lvl;
    end
  end

  // boost switch phases
  logic prim, sec;
  boost_phase_gen #(.HALF(BOOST_HALF)) u_phase (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_en(boost_r),
    .o_primary(prim),
    .o_secondary(sec)
  );

  // ========================================================
  // outputs
  assign o_sw_cap = prim; // R21
  assign o_sw3 = prim; // R21
  assign o_sw2 = sec; // R21
  assign o_sw4 = sec; // R21
  assign o_state = state_r;
  assign o_out_connect = conn_r;
  assign o_ready = rdy_r;
  assign o_ready_bit = rdy_r; // R23
  assign o_warning_flag = warn_r;
  assign o_output_alarm = alarm_r;
  assign o_weak_battery = weak_r;
  assign o_cap_level = lvl_r;
  assign o_charge_target = tgt_r;
  assign o_precharge_on = pre_r;
  assign o_boost_on = boost_r;
  assign o_emergency = ich_r == `ICH_EMERG; // R6
  assign o_ich = ich_r;
  assign o_vmin = vmin_r;
  assign o_regulate = reg_r;
  assign o_vset = vset_r; // R22

  // ========================================================
  // assertions
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  sequence s_od_charge;
    state_r == ST_CHARGE && !cont_r && demand;
  endsequence
  sequence s_od_active;
    state_r == ST_ACTIVE && !cont_r;
  endsequence

  AST_STARTUP_EXIT: assert property ( // R1
    state_r == ST_STARTUP && startup_done |=> state_r == ST_STANDBY)
    else $error("startup did not end in standby");
  AST_STANDBY_LOW: assert property ( // R3
    state_r == ST_STANDBY |-> !o_ready && !o_ready_bit)
    else $error("ready high in standby");
  AST_LEAVE_STBY: assert property ( // R4
    state_r == ST_STANDBY && (ecm_r || demand) |=> state_r == ST_CHARGE)
    else $error("standby not left on enable");
  AST_PAUSE: assert property ( // R7
    state_r == ST_CHARGE && bat_low_s |=> !o_boost_on && !o_precharge_on)
    else $error("charging under battery floor");
  AST_WEAK: assert property ( // R8
    lowbat_done |=> o_weak_battery)
    else $error("weak battery flag missing");
  AST_CEIL: assert property ( // R10
    1'b1 |=> o_charge_target <= $past(ceil_lvl))
    else $error("target above ceiling");
  AST_OD_DONE: assert property ( // R12
    s_od_charge ##0 reached |=> state_r == ST_ACTIVE)
    else $error("no active after end of charge");
  AST_FORCE: assert property ( // R14
    s_od_charge ##0 act_r |=> state_r == ST_ACTIVE)
    else $error("force active ignored");
  AST_OD_END: assert property ( // R15
    s_od_active ##0 !demand |=> state_r == ST_STANDBY)
    else $error("active not ended on clear");
  AST_CONT_BACK: assert property ( // R16
    state_r == ST_ACTIVE && cont_r && ecm_r && !act_r
    |=> state_r == ST_CHARGE)
    else $error("continuous active not back to charge");
  AST_WARN_PULSE: assert property ( // R17
    $rose(o_warning_flag) |-> !o_ready [*8])
    else $error("ready not pulsed low on warning");
  AST_ALARM: assert property ( // R19
    state_r == ST_ACTIVE && out_low_s |=> o_output_alarm && !o_ready)
    else $error("output alarm not raised");
  // checked through reset itself, so the default disable is overridden
  AST_EEW_DEFAULT: assert property ( // R18
    @(posedge i_core_clk) disable iff (1'b0) i_rst |=> !eew_r)
    else $error("early warning enabled after reset");

endmodule // storage_charge_state_sequencer

// ==== dv/host_model.sv ====
// host-side model: settings writes and start pin of the sequencer
`timescale 1ns/100ps
module host_model
  import storage_seq_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic [1:0] i_state,
  output logic [3:0] o_mode,
  output logic [25:0] o_cfg,
  output logic o_cfg_wr,
  output logic o_start
);
  // ========================================================
  // idle values at time zero
  initial begin
    o_mode = 4'h0;
    o_cfg = 26'h0;
    o_cfg_wr = 1'b0;
    o_start = 1'b0;
  end

  // ========================================================
  // one settings write, held back while still in startup
  task automatic wr(input logic [3:0] m, input logic [25:0] c);
    @(posedge i_core_clk);
    while (i_state == ST_STARTUP) begin
      @(posedge i_core_clk);
    end
    o_mode <= m;
    o_cfg <= c;
    o_cfg_wr <= 1'b1;
    @(posedge i_core_clk);
    o_cfg_wr <= 1'b0;
  endtask

  // start pin level
  task automatic pin(input logic v);
    @(posedge i_core_clk);
    o_start <= v;
  endtask
endmodule // host_model

// ==== dv/tb_top.sv ====
// self-checking bench of the storage charge state sequencer
`timescale 1ns/100ps
`include "storage_seq_map.svh"
module tb_top import storage_seq_pkg::*;;
  localparam int SC = 20;
  localparam int EWC = 10;
  logic i_core_clk, i_rst, i_por_ok, i_bat_low, i_above_pre;
  logic i_out_low, i_status_clr, i_cfg_wr, i_start;
  logic [4:0] i_cap_level, o_cap_level, o_charge_target;
  logic [3:0] i_vopt, mode, o_vset;
  logic [25:0] cfg, c;
  logic [1:0] o_state;
  logic [2:0] o_ich, o_vmin;
  logic [13:0] mon;
  int fail_count, cmp_count;

  // ========================================================
  // clock: 100 ns period
  initial begin
    i_core_clk = 1'b0;
    forever begin
      #50 i_core_clk = ~i_core_clk;
    end
  end

  // ========================================================
  // host model and design
  host_model host_model_inst (
    .i_core_clk(i_core_clk), .i_state(o_state), .o_mode(mode),
    .o_cfg(cfg), .o_cfg_wr(i_cfg_wr), .o_start(i_start)
  );

  storage_charge_state_sequencer #(
    .STARTUP_CYC(SC), .WARN_PULSE_CYC(EWC)
  ) storage_charge_state_sequencer_inst (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_por_ok(i_por_ok),
    .i_start(i_start), .i_bat_low(i_bat_low),
    .i_above_pre(i_above_pre), .i_out_low(i_out_low),
    .i_cap_level(i_cap_level), .i_vopt(i_vopt), .i_cfg_wr(i_cfg_wr),
    .i_eod(mode[0]), .i_ecm(mode[1]), .i_act(mode[2]),
    .i_automode(mode[3]), .i_ich(cfg[25:23]), .i_vmin(cfg[22:20]),
    .i_vfix(cfg[19:16]), .i_vcapmax(cfg[15]), .i_prof(cfg[14:9]),
    .i_eew(cfg[8]), .i_vew(cfg[7:4]), .i_vset(cfg[3:0]),
    .i_status_clr(i_status_clr), .o_state(o_state),
    .o_out_connect(mon[7]), .o_ready(mon[0]), .o_ready_bit(mon[13]),
    .o_warning_flag(mon[4]), .o_output_alarm(mon[5]),
    .o_weak_battery(mon[3]), .o_cap_level(o_cap_level),
    .o_charge_target(o_charge_target), .o_precharge_on(mon[1]),
    .o_boost_on(mon[2]), .o_emergency(mon[12]), .o_ich(o_ich),
    .o_vmin(o_vmin), .o_sw_cap(mon[8]), .o_sw2(mon[9]),
    .o_sw3(mon[10]), .o_sw4(mon[11]), .o_regulate(mon[6]),
    .o_vset(o_vset)
  );

  // ========================================================
  // compares, waits and expectations
  task automatic chk_bit(input logic got, input logic exp, input string s);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %b exp %b", $time, s, got, exp);
    end
  endtask

  task automatic chk_vec(input logic [5:0] got, input logic [5:0] exp,
      input string s);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask

  // wait a bounded time for a status bit, then compare
  task automatic wait_bit(input int i, input logic v, input int n);
    @(negedge i_core_clk); // look only at settled values
    for (int k = 0; k < n && mon[i] !== v; k++) begin
      @(negedge i_core_clk);
    end
    chk_bit(mon[i], v, $sformatf("bit %0d", i));
  endtask

  task automatic wait_st(input op_state_t s, input int n);
    @(negedge i_core_clk); // look only at settled values
    for (int k = 0; k < n && o_state !== s; k++) begin
      @(negedge i_core_clk);
    end
    chk_vec(o_state, s, "state");
  endtask

  function automatic logic [25:0] mk(input logic [2:0] ich, vmin,
      input logic [3:0] vfix, input logic cmax, input logic [5:0] prof,
      input logic eew, input logic [3:0] vew, vset);
    return {ich, vmin, vfix, cmax, prof, eew, vew, vset};
  endfunction

  // end-of-charge level: fixed or learned, clamped to the ceiling
  function automatic logic [4:0] tgt(input logic [25:0] f,
      input logic [3:0] vopt);
    logic [4:0] raw, ceil;
    raw = (f[14:9] == `PROF_FIXED) ? {f[19:16], 1'b0} : {vopt, 1'b0};
    ceil = f[15] ? `CEIL_HI : `CEIL_LO;
    return (raw > ceil) ? ceil : raw;
  endfunction

  task automatic final_report();
    $display("checks %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ========================================================
  // watchdog against a hang
  initial begin
    repeat (6000) @(posedge i_core_clk);
    fail_count++;
    $display("mismatch at %0t: timeout", $time);
    final_report();
  end

  // ========================================================
  // main sequence
  initial begin
    fail_count = 0;
    cmp_count = 0;
    void'($urandom(32'h2da4));
    i_rst = 1'b1;
    i_por_ok = 1'b0;
    i_bat_low = 1'b0;
    i_above_pre = 1'b0;
    i_out_low = 1'b0;
    i_status_clr = 1'b0;
    i_cap_level = 5'h00;
    i_vopt = 4'h0;
    c = 26'h0;
    repeat (2) @(posedge i_core_clk);
    i_rst <= 1'b0;
    i_por_ok <= 1'b1;
    // power-on: outputs connect, startup lasts the startup count
    wait_bit(7, 1'b1, 6);
    cyc(SC - 8);
    chk_vec(o_state, ST_STARTUP, "early");
    wait_st(ST_STANDBY, 20);
    chk_bit(mon[0], 1'b0, "ready");
    chk_bit(mon[13], 1'b0, "ready bit");
    // random settings in standby, current codes 0 to 4
    for (int k = 0; k < 15; k++) begin
      c = 26'($urandom);
      c[25:23] = 3'(k % 5);
      if (k % 3 == 0) begin
        c[14:9] = `PROF_FIXED;
      end
      @(posedge i_core_clk);
      i_vopt <= 4'($urandom);
      host_model_inst.wr(4'h0, c);
      cyc(3);
      chk_vec(o_ich, c[25:23], "ich");
      chk_vec(o_vmin, c[22:20], "vmin");
      chk_vec(o_vset, c[3:0], "vset");
      chk_bit(mon[12], c[25:23] == `ICH_EMERG, "emerg");
      chk_vec(o_charge_target, tgt(c, i_vopt), "target");
    end
    // on-demand cycle in emergency current: precharge, boost phases
    c = mk(`ICH_EMERG, 3'h2, 4'ha, 1'b0, `PROF_FIXED, 1'b1, 4'h3, 4'h7);
    @(posedge i_core_clk);
    i_cap_level <= 5'h02;
    host_model_inst.wr(4'h1, c);
    wait_st(ST_CHARGE, 6);
    wait_bit(1, 1'b1, 6);
    chk_bit(mon[2], 1'b0, "boost");
    @(posedge i_core_clk);
    i_above_pre <= 1'b1;
    wait_bit(2, 1'b1, 6);
    wait_bit(8, 1'b1, 14);
    chk_bit(mon[10], 1'b1, "sw3");
    chk_bit(mon[9] | mon[11], 1'b0, "sw2 sw4");
    wait_bit(9, 1'b1, 8);
    chk_bit(mon[11], 1'b1, "sw4");
    chk_bit(mon[8] | mon[10], 1'b0, "swc sw3");
    @(posedge i_core_clk);
    i_cap_level <= 5'h09;
    cyc(3);
    chk_vec(o_cap_level, 5'h09, "level");
    // short floor dip pauses charging, no weak flag
    @(posedge i_core_clk);
    i_bat_low <= 1'b1;
    wait_bit(2, 1'b0, 6);
    cyc(100);
    @(posedge i_core_clk);
    i_bat_low <= 1'b0;
    wait_bit(2, 1'b1, 6);
    chk_bit(mon[3], 1'b0, "weak");
    // long dip sets the weak flag just past 16 us
    @(posedge i_core_clk);
    i_bat_low <= 1'b1;
    cyc(150);
    chk_bit(mon[3], 1'b0, "weak early");
    wait_bit(3, 1'b1, 30);
    @(posedge i_core_clk);
    i_bat_low <= 1'b0;
    i_cap_level <= 5'h14;
    wait_st(ST_ACTIVE, 8);
    wait_bit(0, 1'b1, 4);
    chk_bit(mon[13], mon[0], "ready bit");
    chk_bit(mon[6], 1'b1, "regulate");
    chk_vec(o_vset, 4'h7, "vset");
    // storage sags below warning level: flag and low pulse on ready
    @(posedge i_core_clk);
    i_cap_level <= 5'h05;
    wait_bit(4, 1'b1, 4);
    wait_bit(0, 1'b0, 3);
    cyc(EWC - 4);
    chk_bit(mon[0], 1'b0, "pulse");
    wait_bit(0, 1'b1, 12);
    // output sags: alarm and ready low stay after recovery
    @(posedge i_core_clk);
    i_out_low <= 1'b1;
    wait_bit(5, 1'b1, 6);
    wait_bit(0, 1'b0, 2);
    @(posedge i_core_clk);
    i_out_low <= 1'b0;
    cyc(8);
    chk_bit(mon[5] & ~mon[0], 1'b1, "alarm held");
    host_model_inst.wr(4'h0, c);
    wait_st(ST_STANDBY, 6);
    chk_bit(mon[0], 1'b0, "ready");
    @(posedge i_core_clk);
    i_status_clr <= 1'b1;
    @(posedge i_core_clk);
    i_status_clr <= 1'b0;
    cyc(2);
    chk_bit(mon[3] | mon[4], 1'b0, "flags");
    // forced active before target; alarm gone at charge entry
    @(posedge i_core_clk);
    i_cap_level <= 5'h03;
    host_model_inst.wr(4'h1, c);
    wait_st(ST_CHARGE, 6);
    chk_bit(mon[5], 1'b0, "alarm");
    host_model_inst.wr(4'h5, c);
    wait_st(ST_ACTIVE, 6);
    host_model_inst.wr(4'h0, c);
    wait_st(ST_STANDBY, 6);
    // continuous: hold at target, top up, act toggles active
    c = mk(3'h2, 3'h1, 4'h8, 1'b0, `PROF_FIXED, 1'b0, 4'h0, 4'h3);
    @(posedge i_core_clk);
    i_cap_level <= 5'h04;
    host_model_inst.wr(4'h2, c);
    wait_st(ST_CHARGE, 6);
    @(posedge i_core_clk);
    i_cap_level <= 5'h10;
    wait_bit(0, 1'b1, 6);
    wait_bit(2, 1'b0, 6);
    cyc(4);
    chk_vec(o_state, ST_CHARGE, "hold");
    @(posedge i_core_clk);
    i_cap_level <= 5'h0c;
    wait_bit(2, 1'b1, 6);
    host_model_inst.wr(4'h6, c);
    wait_st(ST_ACTIVE, 6);
    host_model_inst.wr(4'h2, c);
    wait_st(ST_CHARGE, 6);
    host_model_inst.wr(4'h4, c);
    wait_st(ST_ACTIVE, 6);
    host_model_inst.wr(4'h0, c);
    wait_st(ST_STANDBY, 6);
    // start pin counts only in auto mode
    host_model_inst.pin(1'b1);
    cyc(6);
    chk_vec(o_state, ST_STANDBY, "no auto");
    host_model_inst.wr(4'h8, c);
    wait_st(ST_CHARGE, 6);
    host_model_inst.pin(1'b0);
    wait_st(ST_STANDBY, 8);
    final_report();
  end
endmodule // tb_top
